// >>> src/stp_panel.sv
// Purpose: Service test mode logic: panel switches to outputs and indicators.
// Assumes: Key switch off powers the block down, seen here as rst.
// Notes: Voltage and error digits arrive as BCD from the measuring logic.
//
// Notes on behaviour
// - Seat open darkens the three input indicators
// - Red lights on speed control forward
// - Yellow lights on forward/reverse signal
// - Green follows status, flashes fault codes
// - Display cycles voltage digits with blanks
// - Over-current faults replace voltage with codes
// - Scrub-off release toggles brush motor
// - Brush indicator encodes output, current, overload
// - Decrease release steps deck actuator state
// - Four states: off-up, down, off-down, up
// - Off states dark, green flash on current
// - On states steady green, flash without current
// - Horn jogs off actuator if last pressed
// - Horn ignored in on states
// - Squeegee actuator same via increase switch
// - Vacuum release toggles vacuum motor
// - Vacuum indicator encodes output, current, overload
// - Wand lights its indicator, drives nothing
// - Solution release toggles solenoid; red on overload
// - Speed release toggles multimode; brief-off for mode 2
// - Wand held at power-up enters test, shows t
// - Only key off leaves test mode
`timescale 1ns/10ps
`default_nettype none
module stp_panel
    import stp_pkg::*;
#(
    parameter int unsigned P_DEB_CYC = DEB_CYC,
    parameter int unsigned P_FLASH_CYC = FLASH_CYC,
    parameter int unsigned P_BRIEF_CYC = BRIEF_CYC,
    parameter int unsigned P_SHOW_CYC = SHOW_CYC,
    parameter int unsigned P_SBLANK_CYC = SBLANK_CYC,
    parameter int unsigned P_LBLANK_CYC = LBLANK_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Panel switches, high while pressed
    input wire logic [SW_N-1:0] sw_in,
    // Seat and speed controller signals
    input wire logic seat_closed,
    input wire logic sc_fwd,
    input wire logic sc_fwdrev,
    input wire logic sc_status,
    input wire logic [3:0] sc_fault_code,
    // Current sense and overload flags
    input wire logic cur_brush,
    input wire logic cur_vac,
    input wire logic cur_deck,
    input wire logic cur_sqg,
    input wire logic ovl_brush,
    input wire logic ovl_vac,
    input wire logic ovl_sol,
    // Battery voltage digits and error code
    input wire logic [11:0] batt_bcd,
    input wire logic oc_fault,
    input wire logic [7:0] oc_code_bcd,
    // Drive outputs
    output logic test_active,
    output logic brush_on,
    output logic vac_on,
    output logic sol_on,
    output logic multimode_on,
    output logic deck_on,
    output logic deck_down,
    output logic sqg_on,
    output logic sqg_down,
    // Indicators
    output logic led_scrub_grn,
    output logic led_scrub_red,
    output logic led_dec_grn,
    output logic led_inc_grn,
    output logic led_vac_grn,
    output logic led_vac_red,
    output logic led_sol_grn,
    output logic led_sol_red,
    output logic led_speed_grn,
    output logic led_wand,
    output logic led_bat_red,
    output logic led_bat_yel,
    output logic led_bat_grn,
    output logic [4:0] disp_sym
);
    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic stp_act_t act_next(input stp_act_t s);
        case (s)
            ACT_S1: act_next = ACT_S2;
            ACT_S2: act_next = ACT_S3;
            ACT_S3: act_next = ACT_S4;
            default: act_next = ACT_S1;
        endcase
    endfunction : act_next

    // Motor indicator {red, green}; overload wins over all else
    function automatic logic [1:0] motor_led(input logic on, input logic cur,
            input logic ovl, input logic fl, input logic br);
        if (ovl) motor_led = {fl, 1'b0};
        else if (on) motor_led = {1'b0, cur ? 1'b1 : !br};
        else motor_led = {1'b0, cur ? br : 1'b0};
    endfunction : motor_led

    // Actuator green: on states steady or flash, off states dark or flash
    function automatic logic act_led(input logic on, input logic cur,
            input logic fl);
        act_led = on ? (cur ? 1'b1 : fl) : (cur ? fl : 1'b0);
    endfunction : act_led

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers, two flops before any use
    localparam int IN_W = 44;
    logic [IN_W-1:0] raw_w;
    logic [IN_W-1:0] s1_r;
    logic [IN_W-1:0] s2_r;
    assign raw_w = {sw_in, seat_closed, sc_fwd, sc_fwdrev, sc_status, cur_brush,
        cur_vac, cur_deck, cur_sqg, ovl_brush, ovl_vac, ovl_sol, oc_fault,
        sc_fault_code, batt_bcd, oc_code_bcd};
    always_ff @(posedge ref_clk) begin
        s1_r <= raw_w;
        s2_r <= s1_r;
    end

    logic [SW_N-1:0] sw_s;
    logic seat_s, fwd_s, fr_s, stat_s, cb_s, cv_s, cd_s, cq_s;
    logic ob_s, ov_s, os_s, ocf_s;
    logic [3:0] scc_s;
    logic [11:0] bat_s;
    logic [7:0] occ_s;
    assign {sw_s, seat_s, fwd_s, fr_s, stat_s, cb_s, cv_s, cd_s, cq_s, ob_s, ov_s,
        os_s, ocf_s, scc_s, bat_s, occ_s} = s2_r;

    ////////////////////////////////////////////////////////////////////////
    // Debounce, press and release pulses
    logic [SW_N-1:0] db_r;
    logic [SW_N-1:0] db_nxt;
    logic [SW_N-1:0] press_w;
    logic [SW_N-1:0] rel_w;
    logic [31:0] dcnt_r [SW_N];
    // A level counts only after standing a full debounce period
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < SW_N; i++) begin
            if (rst || sw_s[i] == db_r[i]) dcnt_r[i] <= 32'h0;
            else dcnt_r[i] <= dcnt_r[i] + 32'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < SW_N; i++) begin
            db_nxt[i] = (sw_s[i] != db_r[i] && dcnt_r[i] >= P_DEB_CYC - 1)
                ? sw_s[i] : db_r[i];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) db_r <= '0;
        else db_r <= db_nxt;
    end
    assign press_w = db_nxt & ~db_r;
    assign rel_w = ~db_nxt & db_r;

    ////////////////////////////////////////////////////////////////////////
    // Mode: entry decided once the wand level is debounced
    stp_mode_t md_r;
    stp_mode_t md_nxt;
    logic [31:0] st_cnt_r;
    logic in_test;
    always_comb begin
        md_nxt = md_r;
        case (md_r)
            MD_START: if (st_cnt_r >= P_DEB_CYC + 1)
                md_nxt = db_r[SW_WAND] ? MD_ENTRY : MD_IDLE;
            MD_ENTRY: if (!db_r[SW_WAND]) md_nxt = MD_TEST;
            // no switch exits; only reset does
            MD_TEST: md_nxt = MD_TEST;
            MD_IDLE: md_nxt = MD_IDLE;
            default: md_nxt = MD_START;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            md_r <= MD_START;
            st_cnt_r <= 32'h0;
        end else begin
            md_r <= md_nxt;
            st_cnt_r <= (md_r == MD_START) ? st_cnt_r + 32'h1 : st_cnt_r;
        end
    end
    assign in_test = (md_r == MD_TEST);

    ////////////////////////////////////////////////////////////////////////
    // Flash timebase; brief is the short start of each half period with fl_r high
    logic [31:0] fl_cnt_r;
    logic fl_r;
    logic fl_wrap;
    logic brief_w;
    assign fl_wrap = (fl_cnt_r >= P_FLASH_CYC - 1);
    assign brief_w = (fl_cnt_r < P_BRIEF_CYC) && fl_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fl_cnt_r <= 32'h0;
            fl_r <= 1'b0;
        end else begin
            fl_cnt_r <= fl_wrap ? 32'h0 : fl_cnt_r + 32'h1;
            fl_r <= fl_wrap ? !fl_r : fl_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Toggled outputs, actuator states, last switch, overload latches
    logic brush_r, vac_r, sol_r, mm_r;
    stp_act_t deck_st_r, sqg_st_r;
    logic [1:0] last_r;
    logic ovb_r, ovv_r, ovs_r;
    logic [1:0] last_nxt;
    // Horn is the jog key itself, so it must not clear the selection
    assign last_nxt = press_w[SW_DEC] ? LAST_DEC : press_w[SW_INC] ? LAST_INC
        : (|{press_w[SW_N-1:SW_HORN+1], press_w[SW_HORN-1:0]}) ? LAST_OTHER : last_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            brush_r <= 1'b0;
            vac_r <= 1'b0;
            sol_r <= 1'b0;
            mm_r <= 1'b0;
            deck_st_r <= ACT_S1;
            sqg_st_r <= ACT_S1;
            last_r <= LAST_NONE;
            ovb_r <= 1'b0;
            ovv_r <= 1'b0;
            ovs_r <= 1'b0;
        end else if (in_test) begin
            brush_r <= brush_r ^ rel_w[SW_SCRUB];
            vac_r <= vac_r ^ rel_w[SW_VAC];
            sol_r <= sol_r ^ rel_w[SW_SOL];
            mm_r <= mm_r ^ rel_w[SW_SPEED];
            deck_st_r <= rel_w[SW_DEC] ? act_next(deck_st_r) : deck_st_r;
            sqg_st_r <= rel_w[SW_INC] ? act_next(sqg_st_r) : sqg_st_r;
            last_r <= last_nxt;
            // Overloads stay latched until power-down
            ovb_r <= ovb_r | ob_s;
            ovv_r <= ovv_r | ov_s;
            ovs_r <= ovs_r | os_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Actuator drive: Gray bit0 marks down, bit0 xor bit1 marks on
    logic deck_st_on, sqg_st_on, deck_jog, sqg_jog;
    assign deck_st_on = deck_st_r[0] ^ deck_st_r[1];
    assign sqg_st_on = sqg_st_r[0] ^ sqg_st_r[1];
    // horn jog only in off states
    assign deck_jog = !deck_st_on && last_r == LAST_DEC && db_r[SW_HORN];
    assign sqg_jog = !sqg_st_on && last_r == LAST_INC && db_r[SW_HORN];

    ////////////////////////////////////////////////////////////////////////
    // Speed controller fault blink: code blinks then a gap
    // One bit wider so the longest codes keep their gap
    logic [5:0] fc_cnt_r;
    logic [5:0] fc_len;
    logic fc_on;
    assign fc_len = {1'b0, scc_s, 1'b0} + {1'b0, FC_GAP};
    assign fc_on = (fc_cnt_r < {1'b0, scc_s, 1'b0}) && fl_r;
    always_ff @(posedge ref_clk) begin
        if (rst || scc_s == 4'h0) fc_cnt_r <= 6'h0;
        else if (fl_wrap) fc_cnt_r <= (fc_cnt_r >= fc_len - 6'h1) ? 6'h0 : fc_cnt_r + 6'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Status display sequencer
    stp_disp_t ds_r;
    logic [1:0] idx_r;
    logic [31:0] dcyc_r;
    logic [1:0] last_idx;
    logic [31:0] ph_len;
    logic ph_end;
    logic [4:0] sym_w;
    // error codes take two symbols, voltage four
    assign last_idx = ocf_s ? 2'h1 : 2'h3;
    // long blank after the final symbol
    assign ph_len = (ds_r == DS_SHOW) ? P_SHOW_CYC
        : (idx_r >= last_idx) ? P_LBLANK_CYC : P_SBLANK_CYC;
    assign ph_end = (dcyc_r >= ph_len - 1);
    always_ff @(posedge ref_clk) begin
        if (rst || !in_test) begin
            ds_r <= DS_SHOW;
            idx_r <= 2'h0;
            dcyc_r <= 32'h0;
        end else begin
            dcyc_r <= ph_end ? 32'h0 : dcyc_r + 32'h1;
            if (ph_end) begin
                case (ds_r)
                    DS_SHOW: ds_r <= DS_BLANK;
                    DS_BLANK: begin
                        ds_r <= DS_SHOW;
                        idx_r <= (idx_r >= last_idx) ? 2'h0 : idx_r + 2'h1;
                    end
                    default: ds_r <= DS_SHOW;
                endcase
            end
        end
    end
    always_comb begin
        sym_w = SYM_BLANK;
        if (md_r == MD_ENTRY) sym_w = SYM_T;
        else if (in_test && ds_r == DS_SHOW) begin
            case (idx_r)
                2'h0: sym_w = {1'b0, ocf_s ? occ_s[7:4] : bat_s[11:8]};
                2'h1: sym_w = {1'b0, ocf_s ? occ_s[3:0] : bat_s[7:4]};
                2'h2: sym_w = SYM_UNDER;
                default: sym_w = {1'b0, bat_s[3:0]};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicator decode
    logic [1:0] brush_led, vac_led;
    logic seat_ok;
    assign brush_led = motor_led(brush_r, cb_s, ovb_r, fl_r, brief_w);
    assign vac_led = motor_led(vac_r, cv_s, ovv_r, fl_r, brief_w);
    assign seat_ok = in_test && seat_s;

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {test_active, brush_on, vac_on, sol_on, multimode_on} <= 5'h0;
            {deck_on, deck_down, sqg_on, sqg_down} <= 4'h0;
            {led_scrub_grn, led_scrub_red, led_dec_grn, led_inc_grn} <= 4'h0;
            {led_vac_grn, led_vac_red, led_sol_grn, led_sol_red} <= 4'h0;
            {led_speed_grn, led_wand, led_bat_red, led_bat_yel, led_bat_grn} <= 5'h0;
            disp_sym <= SYM_BLANK;
        end else begin
            test_active <= in_test;
            brush_on <= in_test && brush_r;
            vac_on <= in_test && vac_r;
            sol_on <= in_test && sol_r;
            multimode_on <= in_test && mm_r;
            deck_on <= in_test && (deck_st_on || deck_jog);
            deck_down <= in_test && deck_st_r[0];
            sqg_on <= in_test && (sqg_st_on || sqg_jog);
            sqg_down <= in_test && sqg_st_r[0];
            {led_scrub_red, led_scrub_grn} <= in_test ? brush_led : 2'h0;
            {led_vac_red, led_vac_grn} <= in_test ? vac_led : 2'h0;
            led_dec_grn <= in_test && act_led(deck_st_on, cd_s, fl_r);
            led_inc_grn <= in_test && act_led(sqg_st_on, cq_s, fl_r);
            led_sol_red <= in_test && ovs_r && fl_r;
            led_sol_grn <= in_test && !ovs_r && sol_r;
            led_speed_grn <= in_test && (mm_r ? !brief_w : 1'b1);
            led_wand <= in_test && db_r[SW_WAND];
            led_bat_red <= seat_ok && fwd_s;
            led_bat_yel <= seat_ok && fr_s;
            led_bat_grn <= seat_ok && (scc_s != 4'h0 ? fc_on : stat_s);
            disp_sym <= sym_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_dec_rel;
        in_test && rel_w[SW_DEC];
    endsequence
    sequence s_deck_jog;
        in_test && !deck_st_on && last_r == LAST_DEC && db_r[SW_HORN];
    endsequence

    a_seat_dark: assert property (@(posedge ref_clk) disable iff (rst)
        !seat_s |=> !led_bat_red && !led_bat_yel && !led_bat_grn)
        else $error("input indicator lit with seat open");
    a_red_fwd: assert property (@(posedge ref_clk) disable iff (rst)
        in_test && seat_s |=> led_bat_red == $past(fwd_s))
        else $error("red indicator not following forward");
    a_yel_fr: assert property (@(posedge ref_clk) disable iff (rst)
        in_test && seat_s |=> led_bat_yel == $past(fr_s))
        else $error("yellow indicator not following fwd/rev");
    a_brush_toggle: assert property (@(posedge ref_clk) disable iff (rst)
        in_test && rel_w[SW_SCRUB] ##1 1'b1 |=> brush_on != $past(brush_on))
        else $error("brush output did not toggle");
    a_deck_step: assert property (@(posedge ref_clk) disable iff (rst)
        s_dec_rel |=> deck_st_r == act_next($past(deck_st_r)))
        else $error("deck actuator did not step");
    a_deck_jog: assert property (@(posedge ref_clk) disable iff (rst)
        s_deck_jog |=> deck_on && deck_down == $past(deck_st_r[0]))
        else $error("horn jog did not drive deck actuator");
    a_horn_ignored: assert property (@(posedge ref_clk) disable iff (rst)
        in_test && deck_st_on && !rel_w[SW_DEC] |=> deck_on [*2])
        else $error("deck actuator dropped in on state");
    a_test_stays: assert property (@(posedge ref_clk) disable iff (rst)
        md_r == MD_TEST |=> md_r == MD_TEST)
        else $error("test mode left without reset");
    a_entry_t: assert property (@(posedge ref_clk) disable iff (rst)
        md_r == MD_ENTRY |=> disp_sym == SYM_T)
        else $error("entry not showing t");
endmodule : stp_panel
`default_nettype wire

// >>> src/stp_pkg.sv
// Purpose: Shared constants and types for the service test panel control.
// Assumes: One 50 MHz system clock; key switch off removes power (reset).
// Notes: Long counts are top-level parameters defaulting to these values.
package stp_pkg;
    // Clock rate and times in their own units
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned DEB_MS = 10;
    localparam int unsigned FLASH_MS = 250;
    localparam int unsigned BRIEF_MS = 50;
    localparam int unsigned SHOW_MS = 500;
    localparam int unsigned SBLANK_MS = 250;
    localparam int unsigned LBLANK_MS = 1500;
    // Cycle counts derived from the times
    localparam int unsigned DEB_CYC = CLK_HZ / 1000 * DEB_MS;
    localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
    localparam int unsigned BRIEF_CYC = CLK_HZ / 1000 * BRIEF_MS;
    localparam int unsigned SHOW_CYC = CLK_HZ / 1000 * SHOW_MS;
    localparam int unsigned SBLANK_CYC = CLK_HZ / 1000 * SBLANK_MS;
    localparam int unsigned LBLANK_CYC = CLK_HZ / 1000 * LBLANK_MS;
    // Switch vector positions
    localparam int SW_SCRUB = 0;
    localparam int SW_DEC = 1;
    localparam int SW_INC = 2;
    localparam int SW_VAC = 3;
    localparam int SW_SOL = 4;
    localparam int SW_HORN = 5;
    localparam int SW_SPEED = 6;
    localparam int SW_WAND = 7;
    localparam int SW_N = 8;
    // Display symbol codes; 0..9 are the digits themselves
    localparam logic [4:0] SYM_BLANK = 5'h10;
    localparam logic [4:0] SYM_UNDER = 5'h11;
    localparam logic [4:0] SYM_T = 5'h12;
    // Last-pressed selector values
    localparam logic [1:0] LAST_NONE = 2'h0;
    localparam logic [1:0] LAST_DEC = 2'h1;
    localparam logic [1:0] LAST_INC = 2'h2;
    localparam logic [1:0] LAST_OTHER = 2'h3;
    // Fault code blink gap, in flash half periods
    localparam logic [4:0] FC_GAP = 5'h04;
    // Power-up mode, Gray along start, entry, test
    typedef enum logic [1:0] {
        MD_START = 2'b00,
        MD_ENTRY = 2'b01,
        MD_TEST = 2'b11,
        MD_IDLE = 2'b10
    } stp_mode_t;
    // Actuator states 1..4, Gray along the cycle
    typedef enum logic [1:0] {
        ACT_S1 = 2'b00,
        ACT_S2 = 2'b01,
        ACT_S3 = 2'b11,
        ACT_S4 = 2'b10
    } stp_act_t;
    // Display phase
    typedef enum logic {
        DS_SHOW = 1'b0,
        DS_BLANK = 1'b1
    } stp_disp_t;
endpackage : stp_pkg

// >>> verif/stp_far_model.sv
// Purpose: Far-side driver model giving current sense for the driven loads.
// Assumes: One clock; sense follows the drive one clock later.
// Notes: Healthy loads only; no scenario asks for a broken circuit.
`timescale 1ns/10ps
`default_nettype none
module stp_far_model (
    // Clock
    input wire logic ref_clk,
    // Drive outputs seen
    input wire logic brush_on,
    input wire logic vac_on,
    input wire logic deck_on,
    input wire logic sqg_on,
    // Current sense
    output logic cur_brush,
    output logic cur_vac,
    output logic cur_deck,
    output logic cur_sqg
);
    // Sense lags the drive, as a shunt filter would
    always_ff @(posedge ref_clk) begin
        cur_brush <= brush_on;
        cur_vac <= vac_on;
        cur_deck <= deck_on;
        cur_sqg <= sqg_on;
    end
endmodule : stp_far_model
`default_nettype wire

// >>> verif/stp_panel_tb_top.sv
// Purpose: Self-checking bench for the service test panel control.
// Assumes: Short counts so debounce and display steps finish quickly.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
`default_nettype none
module stp_panel_tb_top;
    import stp_pkg::*;
    logic ref_clk, rst, seat_closed, sc_fwd, sc_fwdrev, sc_status, oc_fault;
    logic [SW_N-1:0] sw_in;
    logic [11:0] batt_bcd;
    logic [7:0] oc_code_bcd;
    logic [3:0] sc_fault_code;
    logic ovl_brush, ovl_vac, ovl_sol;
    logic cur_brush, cur_vac, cur_deck, cur_sqg, test_active, brush_on, vac_on, sol_on;
    logic multimode_on, deck_on, deck_down, sqg_on, sqg_down, led_scrub_grn, led_scrub_red;
    logic led_dec_grn, led_inc_grn, led_vac_grn, led_vac_red, led_sol_grn, led_sol_red;
    logic led_speed_grn, led_wand, led_bat_red, led_bat_yel, led_bat_grn;
    logic [4:0] disp_sym;
    int fails = 0;
    int comparisons = 0;
    stp_panel #(.P_DEB_CYC(4), .P_FLASH_CYC(16), .P_BRIEF_CYC(4), .P_SHOW_CYC(20),
        .P_SBLANK_CYC(8), .P_LBLANK_CYC(30)) dut (.ref_clk(ref_clk), .rst(rst),
        .sw_in(sw_in), .seat_closed(seat_closed), .sc_fwd(sc_fwd), .sc_fwdrev(sc_fwdrev),
        .sc_status(sc_status), .sc_fault_code(sc_fault_code), .cur_brush(cur_brush),
        .cur_vac(cur_vac), .cur_deck(cur_deck), .cur_sqg(cur_sqg), .ovl_brush(ovl_brush),
        .ovl_vac(ovl_vac), .ovl_sol(ovl_sol), .batt_bcd(batt_bcd), .oc_fault(oc_fault),
        .oc_code_bcd(oc_code_bcd), .test_active(test_active), .brush_on(brush_on),
        .vac_on(vac_on), .sol_on(sol_on), .multimode_on(multimode_on), .deck_on(deck_on),
        .deck_down(deck_down), .sqg_on(sqg_on), .sqg_down(sqg_down),
        .led_scrub_grn(led_scrub_grn), .led_scrub_red(led_scrub_red),
        .led_dec_grn(led_dec_grn), .led_inc_grn(led_inc_grn), .led_vac_grn(led_vac_grn),
        .led_vac_red(led_vac_red), .led_sol_grn(led_sol_grn), .led_sol_red(led_sol_red),
        .led_speed_grn(led_speed_grn), .led_wand(led_wand), .led_bat_red(led_bat_red),
        .led_bat_yel(led_bat_yel), .led_bat_grn(led_bat_grn), .disp_sym(disp_sym));
    stp_far_model far (.ref_clk(ref_clk), .brush_on(brush_on), .vac_on(vac_on),
        .deck_on(deck_on), .sqg_on(sqg_on), .cur_brush(cur_brush), .cur_vac(cur_vac),
        .cur_deck(cur_deck), .cur_sqg(cur_sqg));
    ////////////////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    // Long enough for sync flops plus debounce on either edge
    task automatic press(input int i);
        sw_in[i] = 1'b1;
        cyc(12);
        sw_in[i] = 1'b0;
        cyc(12);
    endtask : press
    // Bounded wait for a display symbol; a miss ends the run
    task automatic wait_sym(input logic [4:0] s, input int n);
        int k;
        for (k = 0; k < n && disp_sym !== s; k++) cyc(1);
        chk("disp_sym", s, disp_sym);
        if (disp_sym !== s) give_verdict();
    endtask : wait_sym
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_entry();
        sw_in[SW_WAND] = 1'b1;
        cyc(12);
        rst = 1'b0;
        wait_sym(SYM_T, 60);
        sw_in[SW_WAND] = 1'b0;
        cyc(12);
        chk("test_active", 1'b1, test_active);
    endtask : t_entry
    // Each release flips exactly one of the four plain outputs
    task automatic t_toggle();
        int seq[8] = '{SW_SCRUB, SW_VAC, SW_SOL, SW_SPEED, SW_SCRUB, SW_VAC, SW_SOL, SW_SPEED};
        logic [3:0] exp;
        exp = 4'h0;
        foreach (seq[k]) begin
            press(seq[k]);
            exp[3 - (k % 4)] = ~exp[3 - (k % 4)];
            chk("outputs", {1'b0, exp}, {1'b0, brush_on, vac_on, sol_on, multimode_on});
            if (k < 2) chk("motor grn", 1'b1, k ? led_vac_grn : led_scrub_grn);
            if (k == 2) chk("led_sol_grn", 1'b1, led_sol_grn);
        end
        chk("led_speed_grn", 1'b1, led_speed_grn);
    endtask : t_toggle
    // Four states in order, with a horn jog held in each
    task automatic t_act(input int i);
        logic [1:0] st[4] = '{2'b11, 2'b01, 2'b10, 2'b00};
        for (int k = 0; k < 4; k++) begin
            press(i);
            chk("act", {3'h0, st[k]}, (i == SW_DEC) ? {3'h0, deck_on, deck_down} : {3'h0, sqg_on, sqg_down});
            chk("act led", {4'h0, st[k][1]}, (i == SW_DEC) ? led_dec_grn : led_inc_grn);
            sw_in[SW_HORN] = 1'b1;
            cyc(12);
            chk("jog", {3'h0, 1'b1, st[k][0]}, (i == SW_DEC) ? {3'h0, deck_on, deck_down} : {3'h0, sqg_on, sqg_down});
            sw_in[SW_HORN] = 1'b0;
            cyc(12);
            chk("after jog", {3'h0, st[k]}, (i == SW_DEC) ? {3'h0, deck_on, deck_down} : {3'h0, sqg_on, sqg_down});
        end
    endtask : t_act
    task automatic t_seat();
        {sc_fwd, sc_fwdrev, sc_status} = 3'b111;
        cyc(10);
        chk("bat leds open", 5'h00, {2'h0, led_bat_red, led_bat_yel, led_bat_grn});
        seat_closed = 1'b1;
        cyc(10);
        chk("bat leds closed", 5'h07, {2'h0, led_bat_red, led_bat_yel, led_bat_grn});
        sw_in[SW_WAND] = 1'b1;
        cyc(12);
        chk("led_wand", 1'b1, led_wand);
        chk("test_active", 1'b1, test_active);
        sw_in[SW_WAND] = 1'b0;
        cyc(12);
    endtask : t_seat
    // Code 2 gives two green blinks per blink period of (4 + gap) halves
    task automatic t_fault();
        int n;
        logic p;
        n = 0;
        sc_fault_code = 4'h2;
        cyc(40);
        p = led_bat_grn;
        repeat ((2 * 2 + FC_GAP) * 16) begin
            cyc(1);
            if (led_bat_grn && !p) n++;
            p = led_bat_grn;
        end
        chk("fault blinks", 5'h02, n);
        sc_fault_code = 4'h0;
    endtask : t_fault
    // Overloads latch: red flashes half the time, green stays dark
    task automatic t_over();
        int r[3] = '{0, 0, 0};
        int g = 0;
        press(SW_SCRUB);
        press(SW_SOL);
        {ovl_brush, ovl_vac, ovl_sol} = 3'b111;
        cyc(4);
        {ovl_brush, ovl_vac, ovl_sol} = 3'b000;
        cyc(4);
        repeat (32) begin
            cyc(1);
            r[0] += led_scrub_red;
            r[1] += led_vac_red;
            r[2] += led_sol_red;
            g += led_scrub_grn + led_vac_grn + led_sol_grn;
        end
        foreach (r[k]) chk("red flash", 5'h10, r[k]);
        chk("green off", 5'h00, g);
    endtask : t_over
    // Voltage 36.0, then fault code 27; gaps are tight so order matters
    task automatic t_disp();
        wait_sym(5'h03, 200);
        wait_sym(SYM_BLANK, 22);
        wait_sym(5'h06, 10);
        wait_sym(SYM_BLANK, 22);
        wait_sym(SYM_UNDER, 10);
        wait_sym(SYM_BLANK, 22);
        wait_sym(5'h00, 10);
        oc_fault = 1'b1;
        wait_sym(5'h02, 200);
        wait_sym(SYM_BLANK, 22);
        wait_sym(5'h07, 10);
    endtask : t_disp
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        sw_in = '0;
        {seat_closed, sc_fwd, sc_fwdrev, sc_status, oc_fault} = 5'h00;
        batt_bcd = 12'h360;
        oc_code_bcd = 8'h27;
        sc_fault_code = 4'h0;
        {ovl_brush, ovl_vac, ovl_sol} = 3'h0;
        t_entry();
        t_toggle();
        t_act(SW_DEC);
        t_act(SW_INC);
        t_seat();
        t_fault();
        t_over();
        t_disp();
        give_verdict();
    end
endmodule : stp_panel_tb_top
`default_nettype wire
